// ### pdm_ctrl.sv
// module: power-down mode sequencer with its control registers
// How it works
// - active high-speed plus seven reduced-power modes, eight modes in all
// - medium-speed active and sleep tick oscillator clock by 8, 16, 32 or 64
// - subactive runs everything on subclock; subclock is watch clock by 2, 4, 8
// - both sleep modes stop the processor; peripherals keep the system clock
// - subsleep and watch halt the processor; peripherals run from subclock
// - standby stops processor and every peripheral
// - each peripheral can be stopped alone by its halt bit, in any mode
// - sleep goes to sleep/subsleep with standby bit 0, standby/watch with 1 and direct bit 0
// - leaving standby, subactive or watch for active waits the coded states
// - on watch exit, low-speed bit 0 runs processor on system clock, 1 subclock
// - sleep target comes from watch, standby, low-speed, direct and medium bits
// - active clock code 10 divides by 32, 11 by 64, reset value 11
// - after standby, watch or sleep resume medium speed if medium bit is 1
// - wait code top bit sits in bit 0 of third register, resets to 0
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pdm_ctrl
	import pdm_pkg::*;
(
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic [3:0]        addr_in,
	input  wire logic [7:0]        wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	input  wire logic              sleep_in,
	input  wire logic              wake_in,
	input  wire logic              watch_clk_in,
	output logic [7:0]             rdata_out,
	output pdm_pkg::pdm_clk_t      clk_out,
	output pdm_pkg::pdm_mode_t     mode_out
);
	import pdm_pkg::*;

	logic [7:0] one_q;
	logic [7:0] two_q;
	logic [7:0] three_q;
	logic [7:0] halt_q;
	pdm_mode_t  mode_q;
	pdm_mode_t  mode_d;
	pdm_mode_t  after_wait_q;
	logic [11:0] wait_cnt_q;
	logic [5:0]  osc_div_q;
	logic [2:0]  sub_div_q;
	logic        wsync1_q;
	logic        wsync2_q;
	logic        wsync3_q;
	logic        sleep_sync1_q;
	logic        sleep_sync2_q;
	logic        wake_sync1_q;
	logic        wake_sync2_q;
	logic [7:0]  rdata_q;
	pdm_clk_t    clk_q;
	logic [3:0]  sts;
	logic        watch_edge;
	logic        osc_tick;
	logic        sub_tick;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// number of wait states for a four-bit stabilisation code
	function automatic logic [11:0] wait_states(input logic [3:0] code);
		case (code)
			4'h0:    wait_states = 12'h008;
			4'h1:    wait_states = 12'h010;
			4'h2:    wait_states = 12'h020;
			4'h3:    wait_states = 12'h040;
			4'h4:    wait_states = 12'h080;
			4'h5:    wait_states = 12'h002;
			4'h6:    wait_states = 12'h100;
			4'h7:    wait_states = 12'h200;
			4'hD:    wait_states = 12'h004;
			default: wait_states = 12'h800;
		endcase
	endfunction

	// active mode after a wake, picked by the medium-speed bit
	function automatic pdm_mode_t resume_mode(input logic medium_speed_select);
		resume_mode = medium_speed_select ? MODE_ACT_MS : MODE_ACT_HS;
	endfunction

	// four-bit wait code; its top bit lives in the third register
	assign sts = {three_q[0], one_q[ONE_STS_H:ONE_STS_L]};

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------

	// watch clock: two flops, a third one only for the edge detect
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wsync1_q <= 1'b0;
			wsync2_q <= 1'b0;
			wsync3_q <= 1'b0;
		end else begin
			wsync1_q <= watch_clk_in;
			wsync2_q <= wsync1_q;
			wsync3_q <= wsync2_q;
		end
	end

	// sleep request pin, two flops before use
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sleep_sync1_q <= 1'b0;
			sleep_sync2_q <= 1'b0;
		end else begin
			sleep_sync1_q <= sleep_in;
			sleep_sync2_q <= sleep_sync1_q;
		end
	end

	// wake event pin, two flops before use
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wake_sync1_q <= 1'b0;
			wake_sync2_q <= 1'b0;
		end else begin
			wake_sync1_q <= wake_in;
			wake_sync2_q <= wake_sync1_q;
		end
	end

	// rising edge of the watch clock, seen once per period
	assign watch_edge = wsync2_q & ~wsync3_q;

	// ------------------------------------------------------------
	// clock dividers
	// ------------------------------------------------------------

	// free-running oscillator divider
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			osc_div_q <= 6'h00;
		end else begin
			osc_div_q <= osc_div_q + 6'h01;
		end
	end

	// medium-speed tick from the active clock field
	always_comb begin
		case (one_q[1:0])
			ACLK_DIV8:  osc_tick = (osc_div_q[2:0] == 3'h7);
			ACLK_DIV16: osc_tick = (osc_div_q[3:0] == 4'hF);
			ACLK_DIV32: osc_tick = (osc_div_q[4:0] == 5'h1F);
			default:    osc_tick = (osc_div_q == DIV64_MAX);
		endcase
	end

	// subclock divider counts watch clock edges; the watch clock must
	// stay below half the core clock or edges are lost
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sub_div_q <= 3'h0;
		end else if (watch_edge) begin
			sub_div_q <= sub_div_q + 3'h1;
		end
	end

	// subclock ratio, unchanged by watch mode
	always_comb begin
		case (two_q[1:0])
			SCLK_DIV2: sub_tick = watch_edge & sub_div_q[0];
			SCLK_DIV4: sub_tick = watch_edge & (sub_div_q[1:0] == 2'h3);
			default:   sub_tick = watch_edge & (sub_div_q == 3'h7);
		endcase
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------

	// software writes; active clock field only taken in allowed modes
	// a frozen divider code keeps a running medium clock from jumping
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			one_q   <= RST_CTRL_ONE;
			two_q   <= RST_CTRL_TWO;
			three_q <= RST_CTRL_THREE;
			halt_q  <= RST_HALT;
		end else if (wr_in) begin
			if (addr_in == ADDR_CTRL_ONE) begin
				one_q[7:2] <= wdata_in[7:2];
				if (mode_q == MODE_ACT_HS || mode_q == MODE_SUBACT) begin
					one_q[1:0] <= wdata_in[1:0];
				end
			end else if (addr_in == ADDR_CTRL_TWO) begin
				two_q <= (wdata_in & ~RO_TWO_MASK) | RO_TWO_MASK;
			end else if (addr_in == ADDR_CTRL_THREE) begin
				three_q <= (wdata_in & ~RO_THREE_MASK) | RO_THREE_MASK;
			end else if (addr_in == ADDR_HALT) begin
				halt_q <= wdata_in;
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	// cleared between reads so stale data never passes for an answer
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= 8'h00;
		end else if (rd_in) begin
			if (addr_in == ADDR_CTRL_ONE) begin
				rdata_q <= one_q;
			end else if (addr_in == ADDR_CTRL_TWO) begin
				rdata_q <= two_q;
			end else if (addr_in == ADDR_CTRL_THREE) begin
				rdata_q <= three_q;
			end else if (addr_in == ADDR_HALT) begin
				rdata_q <= halt_q;
			end else if (addr_in == ADDR_STATUS) begin
				rdata_q <= mode_q[7:0] | {7'h00, mode_q[8]};
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// mode sequencer
	// ------------------------------------------------------------

	// sleep target and wake-up decisions
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MODE_ACT_HS, MODE_ACT_MS: begin
				if (sleep_sync2_q) begin
					if (!one_q[ONE_SOFTWARE_STANDBY_SEL]) begin
						mode_d = MODE_SLEEP_HS;
						if (one_q[ONE_LOW_SPEED_SELECT]) begin
							mode_d = MODE_SUBSLEEP;
						end else if (two_q[TWO_MEDIUM_SPEED_SELECT]) begin
							mode_d = MODE_SLEEP_MS;
						end
					end else if (two_q[TWO_DIRECT_TRANSFER_SELECT]) begin
						mode_d = one_q[ONE_LOW_SPEED_SELECT] ? MODE_SUBACT : MODE_ACT_MS;
					end else begin
						mode_d = one_q[ONE_WSEL] ? MODE_WATCH : MODE_STANDBY;
					end
				end
			end
			MODE_SUBACT: begin
				if (sleep_sync2_q) begin
					if (!one_q[ONE_SOFTWARE_STANDBY_SEL]) begin
						mode_d = MODE_SUBSLEEP;
					end else if (two_q[TWO_DIRECT_TRANSFER_SELECT] && !one_q[ONE_LOW_SPEED_SELECT]) begin
						mode_d = MODE_WAIT;
					end else begin
						mode_d = one_q[ONE_WSEL] ? MODE_WATCH : MODE_STANDBY;
					end
				end
			end
			MODE_SLEEP_HS, MODE_SLEEP_MS: begin
				if (wake_sync2_q) begin
					mode_d = resume_mode(two_q[TWO_MEDIUM_SPEED_SELECT]);
				end
			end
			MODE_SUBSLEEP: begin
				if (wake_sync2_q) begin
					mode_d = MODE_SUBACT;
				end
			end
			MODE_WATCH: begin
				if (wake_sync2_q) begin
					mode_d = one_q[ONE_LOW_SPEED_SELECT] ? MODE_SUBACT : MODE_WAIT;
				end
			end
			MODE_STANDBY: begin
				if (wake_sync2_q) begin
					mode_d = MODE_WAIT;
				end
			end
			MODE_WAIT: begin
				if (wait_cnt_q == 12'h001) begin
					mode_d = after_wait_q;
				end
			end
			default: mode_d = MODE_ACT_HS;
		endcase
	end

	// mode register
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= MODE_ACT_HS;
		end else begin
			mode_q <= mode_d;
		end
	end

	// stabilisation wait counter and resume target
	// loads only on entry to the wait, so a stale count never cuts it short
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_cnt_q   <= 12'h000;
			after_wait_q <= MODE_ACT_HS;
		end else if (mode_d == MODE_WAIT && mode_q != MODE_WAIT) begin
			wait_cnt_q   <= wait_states(sts);
			after_wait_q <= resume_mode(two_q[TWO_MEDIUM_SPEED_SELECT]);
		end else if (wait_cnt_q != 12'h000) begin
			wait_cnt_q <= wait_cnt_q - 12'h001;
		end
	end

	// ------------------------------------------------------------
	// clock enables
	// ------------------------------------------------------------

	// gating per mode, module halt bits applied on top
	// built from mode_d so enables change on the same edge as mode_out
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_q <= '0;
		end else begin
			clk_q.cpu_en   <= (mode_d == MODE_ACT_HS) || (mode_d == MODE_ACT_MS)
				|| (mode_d == MODE_SUBACT);
			clk_q.sys_tick <= (mode_d == MODE_ACT_HS) || (mode_d == MODE_SLEEP_HS)
				|| (((mode_d == MODE_ACT_MS) || (mode_d == MODE_SLEEP_MS)) && osc_tick);
			clk_q.sub_tick <= ((mode_d == MODE_SUBACT) || (mode_d == MODE_SUBSLEEP)
				|| (mode_d == MODE_WATCH)) && sub_tick;
			clk_q.mod_en   <= (mode_d == MODE_STANDBY || mode_d == MODE_WAIT)
				? '0 : ~halt_q;
		end
	end

	assign rdata_out = rdata_q;
	assign clk_out   = clk_q;
	assign mode_out  = mode_q;

endmodule
`default_nettype wire

// ### pdm_ctrl_props.sv
// checker: port-level properties of the power-down mode control
`timescale 1ns/1ns
`default_nettype none
module pdm_ctrl_props
	import pdm_pkg::*;
(
	input  wire logic               core_clk_in,
	input  wire logic               rst_in,
	input  wire logic [3:0]         addr_in,
	input  wire logic [7:0]         wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	input  wire logic               sleep_in,
	input  wire logic               wake_in,
	input  wire logic               watch_clk_in,
	input  wire logic [7:0]         rdata_out,
	input  wire pdm_pkg::pdm_clk_t  clk_out,
	input  wire pdm_pkg::pdm_mode_t mode_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	property p_one_hot; $onehot(mode_out); endproperty
	a_one_hot: assert property (p_one_hot) else $error("mode not one-hot");
	property p_ms_tick;
		clk_out.sys_tick && mode_out == MODE_ACT_MS ##1 mode_out == MODE_ACT_MS |-> !clk_out.sys_tick;
	endproperty
	a_ms_tick: assert property (p_ms_tick) else $error("medium tick too close");
	property p_sleep_cpu; mode_out inside {MODE_SLEEP_HS, MODE_SLEEP_MS} |-> !clk_out.cpu_en; endproperty
	a_sleep_cpu: assert property (p_sleep_cpu) else $error("cpu runs in sleep");
	property p_sub_cpu; mode_out inside {MODE_SUBSLEEP, MODE_WATCH} |-> !clk_out.cpu_en; endproperty
	a_sub_cpu: assert property (p_sub_cpu) else $error("cpu runs in subsleep or watch");
	property p_standby;
		mode_out == MODE_STANDBY |-> !clk_out.cpu_en && clk_out.mod_en == 8'h00 && !clk_out.sys_tick;
	endproperty
	a_standby: assert property (p_standby) else $error("standby not fully stopped");
	property p_halt;
		wr_in && addr_in == ADDR_HALT && wdata_in == 8'hFF && mode_out == MODE_ACT_HS
			|-> ##[1:3] clk_out.mod_en == 8'h00;
	endproperty
	a_halt: assert property (p_halt) else $error("halted modules still enabled");
	property p_enter; $rose(sleep_in) && mode_out == MODE_ACT_HS |-> ##[1:5] mode_out != MODE_ACT_HS; endproperty
	a_enter: assert property (p_enter) else $error("sleep request not taken");
	property p_wait_hold; mode_out == MODE_WAIT |-> !clk_out.cpu_en && clk_out.mod_en == 8'h00; endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait does not hold core");
	property p_watch_exit;
		mode_out == MODE_WATCH ##1 mode_out != MODE_WATCH |-> mode_out inside {MODE_SUBACT, MODE_WAIT};
	endproperty
	a_watch_exit: assert property (p_watch_exit) else $error("bad watch exit target");
	property p_ctrl3; rd_in && addr_in == ADDR_CTRL_THREE |=> rdata_out[7:1] == 7'h7F; endproperty
	a_ctrl3: assert property (p_ctrl3) else $error("ctrl three upper bits not ones");
endmodule
`default_nettype wire

// ### pdm_pkg.sv
// package: register map, field positions and mode codes of the power-down mode control
package pdm_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL_ONE   = 4'h0;
	localparam logic [3:0] ADDR_CTRL_TWO   = 4'h1;
	localparam logic [3:0] ADDR_CTRL_THREE = 4'h2;
	localparam logic [3:0] ADDR_HALT       = 4'h3;
	localparam logic [3:0] ADDR_STATUS     = 4'h4;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ONE_SOFTWARE_STANDBY_SEL  = 7;
	localparam int ONE_STS_H = 6;
	localparam int ONE_STS_L = 4;
	localparam int ONE_LOW_SPEED_SELECT  = 3;
	localparam int ONE_WSEL  = 2;
	localparam int TWO_DIRECT_TRANSFER_SELECT  = 3;
	localparam int TWO_MEDIUM_SPEED_SELECT  = 2;

	// ------------------------------------------------------------
	// reset values, read-only masks and module count
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CTRL_ONE   = 8'h03;
	localparam logic [7:0] RST_CTRL_TWO   = 8'hF0;
	localparam logic [7:0] RST_CTRL_THREE = 8'hFE;
	localparam logic [7:0] RST_HALT       = 8'h00;
	localparam logic [7:0] RO_TWO_MASK    = 8'hE0;
	localparam logic [7:0] RO_THREE_MASK  = 8'hFE;
	localparam int         NUM_MODULES    = 8;

	// ------------------------------------------------------------
	// divider codes
	// ------------------------------------------------------------
	localparam logic [1:0] ACLK_DIV8  = 2'h0;
	localparam logic [1:0] ACLK_DIV16 = 2'h1;
	localparam logic [1:0] ACLK_DIV32 = 2'h2;
	localparam logic [1:0] ACLK_DIV64 = 2'h3;
	localparam logic [1:0] SCLK_DIV8  = 2'h0;
	localparam logic [1:0] SCLK_DIV4  = 2'h1;
	localparam logic [1:0] SCLK_DIV2  = 2'h2;
	localparam logic [5:0] DIV64_MAX  = 6'h3F;

	// ------------------------------------------------------------
	// operating modes (one-hot)
	// ------------------------------------------------------------
	typedef enum logic [8:0] {
		MODE_ACT_HS   = 9'h001,
		MODE_ACT_MS   = 9'h002,
		MODE_SUBACT   = 9'h004,
		MODE_SLEEP_HS = 9'h008,
		MODE_SLEEP_MS = 9'h010,
		MODE_SUBSLEEP = 9'h020,
		MODE_WATCH    = 9'h040,
		MODE_STANDBY  = 9'h080,
		MODE_WAIT     = 9'h100
	} pdm_mode_t;

	// clock enables handed to the core and peripherals
	typedef struct packed {
		logic                   cpu_en;
		logic                   sys_tick;
		logic                   sub_tick;
		logic [NUM_MODULES-1:0] mod_en;
	} pdm_clk_t;

endpackage

// ### tb_top.sv
// testbench: register, mode-walk and divider checks of the power-down mode control
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pdm_pkg::*;
	// ----------------------------------------
	// signals and scoreboard
	// ----------------------------------------
	logic        core_clk, rst, wr, rd, slp, wake, wclk, rd_d, gap_ok;
	logic [3:0]  addr, wcnt;
	logic [7:0]  wdata, rdata;
	logic [31:0] seed;
	pdm_clk_t    ck;
	pdm_mode_t   mode, last;
	int          fails, checks, wait_n, gap, gap_exp, i;
	logic [7:0]  q8[$];
	pdm_mode_t   qm[$];
	int          qw[$];
	pdm_ctrl DUT (.core_clk_in(core_clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .sleep_in(slp), .wake_in(wake), .watch_clk_in(wclk),
		.rdata_out(rdata), .clk_out(ck), .mode_out(mode));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic chkm(input pdm_mode_t e, input pdm_mode_t s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] mode exp %h got %h", e, s);
		end
	endtask
	task automatic chkn(input string n, input int e, input int s);
		checks++;
		if (s != e) begin
			fails++;
			$display("[ERR] %s exp %0d got %0d", n, e, s);
		end
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		q8.push_back(e);
		@(posedge core_clk);
		rd <= 1'b0;
	endtask
	// reset, program, sleep, wake and note every mode step expected
	task automatic trip(input logic [7:0] c1, c2, c3, input pdm_mode_t tgt, input int wn,
			input pdm_mode_t res, input int g);
		int k;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		gap_exp = g;
		bus_wr(ADDR_CTRL_ONE, c1);
		bus_wr(ADDR_CTRL_TWO, c2);
		bus_wr(ADDR_CTRL_THREE, c3);
		qm.push_back(tgt);
		@(posedge core_clk);
		slp <= 1'b1;
		for (k = 0; k < 20 && mode !== tgt; k++) @(posedge core_clk);
		slp <= 1'b0;
		chkm(tgt, mode);
		if (res != tgt) begin
			if (wn > 0) begin
				qm.push_back(MODE_WAIT);
				qw.push_back(wn);
			end
			qm.push_back(res);
			@(posedge core_clk);
			wake <= 1'b1;
			for (k = 0; k < 700 && mode !== res; k++) @(posedge core_clk);
			wake <= 1'b0;
			chkm(res, mode);
		end
		repeat (150) @(posedge core_clk);
		$display("test trip %h done", tgt);
	endtask
	task final_report;
		if (q8.size() + qm.size() + qw.size() != 0) fails++; // notes never answered
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// clocks, monitors, watchdog
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// slow watch clock, eight core cycles per period, parked low in reset
	always @(posedge core_clk) begin
		wcnt <= rst ? 4'h0 : wcnt + 4'h1;
		wclk <= wcnt[2] & ~rst;
	end
	// read data stand in the cycle after the read strobe
	always @(posedge core_clk) begin
		if (rd_d) chk8("rdata", q8.pop_front(), rdata);
		rd_d <= rd;
	end
	// mode steps, wait length and medium tick spacing
	always @(negedge core_clk) begin
		if (rst) begin
			last = MODE_ACT_HS;
			wait_n = 0;
			gap_ok = 1'b0;
		end else begin
			if (mode !== last) begin
				chkm((qm.size() > 0) ? qm.pop_front() : pdm_mode_t'(9'h000), mode);
				if (last == MODE_WAIT) chkn("wait", (qw.size() > 0) ? qw.pop_front() : -1, wait_n);
				last = mode;
				wait_n = 0;
			end
			if (mode == MODE_WAIT) wait_n++;
			if (mode == MODE_ACT_MS || mode == MODE_SUBACT) begin
				gap++;
				if ((mode == MODE_ACT_MS) ? ck.sys_tick : ck.sub_tick) begin
					if (gap_ok) chkn("tick gap", gap_exp, gap);
					gap_ok = 1'b1;
					gap = 0;
				end
			end else gap_ok = 1'b0;
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		final_report;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, wr, rd, slp, wake} = 5'h10;
		{addr, wdata} = 12'h000;
		seed = 32'hE4A9;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		bus_rd(ADDR_CTRL_ONE, 8'h03);
		bus_rd(ADDR_CTRL_TWO, 8'hF0);
		bus_rd(ADDR_CTRL_THREE, 8'hFE);
		bus_rd(ADDR_STATUS, 8'h01);
		bus_rd(4'hF, 8'h00);
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			bus_wr(ADDR_CTRL_TWO, seed[7:0]);
			bus_rd(ADDR_CTRL_TWO, seed[7:0] | RO_TWO_MASK);
			bus_wr(ADDR_CTRL_THREE, seed[15:8]);
			bus_rd(ADDR_CTRL_THREE, seed[15:8] | RO_THREE_MASK);
			bus_wr(ADDR_CTRL_ONE, seed[23:16]);
			bus_rd(ADDR_CTRL_ONE, seed[23:16]);
			bus_wr(ADDR_HALT, seed[31:24]);
			bus_rd(ADDR_HALT, seed[31:24]);
			chk8("mod_en", ~seed[31:24], ck.mod_en);
			bus_wr(4'hF, seed[7:0]);
			bus_rd(4'hF, 8'h00);
		end
		bus_wr(ADDR_HALT, 8'hFF);
		repeat (3) @(posedge core_clk);
		chk8("mod_en", 8'h00, ck.mod_en);
		$display("test regs done");
		for (i = 0; i < 4; i++)
			trip(8'h80 | i[7:0], 8'hF8, 8'hFE, MODE_ACT_MS, 0, MODE_ACT_MS, 8 << i);
		bus_wr(ADDR_CTRL_ONE, 8'h00);
		bus_rd(ADDR_CTRL_ONE, 8'h03);
		trip(8'h03, 8'hF0, 8'hFE, MODE_SLEEP_HS, 0, MODE_ACT_HS, 64);
		trip(8'h03, 8'hF4, 8'hFE, MODE_SLEEP_MS, 0, MODE_ACT_MS, 64);
		trip(8'hD3, 8'hF4, 8'hFF, MODE_STANDBY, 4, MODE_ACT_MS, 64);
		trip(8'hD3, 8'hF0, 8'hFE, MODE_STANDBY, 2, MODE_ACT_HS, 64);
		trip(8'hC7, 8'hF0, 8'hFE, MODE_WATCH, 128, MODE_ACT_HS, 64);
		trip(8'h8F, 8'hF2, 8'hFE, MODE_WATCH, 0, MODE_SUBACT, 16);
		final_report;
	end
endmodule
bind pdm_ctrl pdm_ctrl_props u_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sleep_in(sleep_in),
	.wake_in(wake_in), .watch_clk_in(watch_clk_in), .rdata_out(rdata_out), .clk_out(clk_out),
	.mode_out(mode_out));
`default_nettype wire
